// ===== hw/fscr_bank.sv
// flash status and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module fscr_bank
   import fscr_pkg::*;
#(
   parameter int WRITE_CYCLES = SR_WRITE_CYCLES
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         power_cycle,
   input  wire fscr_req_t    req,
   input  wire logic         array_done,
   output fscr_status_t      status,
   output logic              cmd_accept,
   output logic              cmd_reject,
   output fscr_array_t       array_cmd,
   output logic              array_hold,
   output logic [3:0]        dummy_dual,
   output logic [3:0]        dummy_quad,
   output logic [1:0]        strength,
   output logic              quad_on,
   output logic [2:0]        otp_locked
);

   generate
      if (WRITE_CYCLES < 1 || WRITE_CYCLES > 65535) begin : g_bad_cycles
         $error("fscr_bank: WRITE_CYCLES out of range");
      end
   endgenerate

   typedef enum logic [1:0] {
      FSCR_IDLE,
      FSCR_SR_WRITE,
      FSCR_ARRAY_RUN,
      FSCR_PAUSED
   } fscr_phase_t;

   ////////////////////////////////////////////////////////////////////////////
   // state
   fscr_phase_t  phase_reg,    phase_next;
   logic [4:0]   prot_reg,     prot_next;
   logic [1:0]   lock_reg,     lock_next;
   logic         invert_reg,   invert_next;
   logic [2:0]   otp_reg,      otp_next;
   logic         dummy_reg,    dummy_next;
   logic [1:0]   drive_reg,    drive_next;
   logic         latch_reg,    latch_next;
   logic         epause_reg,   epause_next;
   logic         ppause_reg,   ppause_next;
   logic [7:0]   pend_reg,     pend_next;
   logic [1:0]   sel_reg,      sel_next;
   logic [15:0]  timer_reg,    timer_next;
   fscr_op_t     op_reg,       op_next;
   logic         accept_reg,   accept_next;
   logic         reject_reg,   reject_next;
   fscr_array_t  array_reg,    array_next;

   logic         busy;
   logic         in_prot;
   logic         chip_ok;
   logic         ok;

   fscr_guard #(
      .AW     (ADDR_W)
   ) u_guard (
      .prot   (prot_reg),
      .invert (invert_reg),
      .addr   (req.addr),
      .hit    (in_prot)
   );

   // a paused operation is not busy; the host may read while it waits
   assign busy    = (phase_reg == FSCR_SR_WRITE) || (phase_reg == FSCR_ARRAY_RUN);
   assign chip_ok = ((prot_reg[2:0] == 3'h0) && !invert_reg)
                 || ((prot_reg[2:0] == 3'h7) && invert_reg);

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      phase_next  = phase_reg;
      prot_next   = prot_reg;
      lock_next   = lock_reg;
      invert_next = invert_reg;
      otp_next    = otp_reg;
      dummy_next  = dummy_reg;
      drive_next  = drive_reg;
      latch_next  = latch_reg;
      epause_next = epause_reg;
      ppause_next = ppause_reg;
      pend_next   = pend_reg;
      sel_next    = sel_reg;
      timer_next  = timer_reg;
      op_next     = op_reg;
      accept_next = 1'b0;
      reject_next = 1'b0;
      array_next  = array_reg;
      array_next.start = 1'b0;
      ok          = 1'b0;

      if (power_cycle) begin
         // power loss abandons any internal operation; non-volatile bits stay, but lock mode 10 returns to 00
         phase_next  = FSCR_IDLE;
         latch_next  = 1'b0;
         epause_next = 1'b0;
         ppause_next = 1'b0;
         if (lock_reg == LOCK_DOWN) begin
            lock_next = LOCK_OPEN;
         end
      end else begin
         case (phase_reg)
            FSCR_SR_WRITE: begin
               timer_next = timer_reg - 16'h0001;
               if (timer_reg == 16'h0001) begin
                  // only writable fields are touched; read-only bits keep state
                  case (sel_reg)
                     2'h0: begin
                        prot_next    = pend_reg[PROT_HI_BIT:PROT_LO_BIT];
                        lock_next[0] = pend_reg[LOCK_LO_BIT];
                     end
                     2'h1: begin
                        lock_next[1] = pend_reg[LOCK_HI_BIT];
                        otp_next     = otp_reg | pend_reg[OTP_HI_BIT:OTP_LO_BIT];
                        invert_next  = pend_reg[INVERT_BIT];
                     end
                     default: begin
                        dummy_next = pend_reg[DUMMY_BIT];
                        drive_next = pend_reg[STRENGTH_HI:STRENGTH_LO];
                     end
                  endcase
                  latch_next = 1'b0;
                  phase_next = FSCR_IDLE;
               end
            end
            FSCR_ARRAY_RUN: begin
               if (array_done) begin
                  latch_next = 1'b0;
                  phase_next = FSCR_IDLE;
               end
            end
            FSCR_IDLE, FSCR_PAUSED: begin
            end
            default: begin
               phase_next = FSCR_IDLE;
            end
         endcase

         if (req.valid) begin
            case (req.code)
               FSCR_ENABLE_WRITE: begin
                  ok = !busy;
                  if (ok) begin
                     latch_next = 1'b1;
                  end
               end
               FSCR_DISABLE_WRITE: begin
                  ok = !busy;
                  if (ok) begin
                     latch_next = 1'b0;
                  end
               end
               FSCR_STATUS_WRITE_1, FSCR_STATUS_WRITE_2, FSCR_STATUS_WRITE_3: begin
                  // lock mode 10 and 11 both refuse; only the power cycle differs
                  ok = (phase_reg == FSCR_IDLE) && latch_reg && !lock_reg[1];
                  if (ok) begin
                     pend_next  = req.data;
                     sel_next   = (req.code == FSCR_STATUS_WRITE_1) ? 2'h0 :
                                  (req.code == FSCR_STATUS_WRITE_2) ? 2'h1 : 2'h2;
                     timer_next = 16'(WRITE_CYCLES);
                     phase_next = FSCR_SR_WRITE;
                  end
               end
               FSCR_PAGE_WRITE, FSCR_SECTOR_WIPE, FSCR_BLOCK_WIPE, FSCR_CHIP_WIPE: begin
                  ok = (phase_reg == FSCR_IDLE) && latch_reg
                    && ((req.code == FSCR_CHIP_WIPE) ? chip_ok : !in_prot);
                  if (ok) begin
                     op_next = (req.code == FSCR_PAGE_WRITE)  ? FSCR_OP_PROGRAM :
                               (req.code == FSCR_SECTOR_WIPE) ? FSCR_OP_SECTOR  :
                               (req.code == FSCR_BLOCK_WIPE)  ? FSCR_OP_BLOCK   :
                                                                FSCR_OP_CHIP;
                     array_next.start = 1'b1;
                     array_next.kind  = op_next;
                     array_next.addr  = req.addr;
                     phase_next       = FSCR_ARRAY_RUN;
                  end
               end
               FSCR_SUSPEND: begin
                  ok = (phase_reg == FSCR_ARRAY_RUN) && !array_done;
                  if (ok) begin
                     phase_next = FSCR_PAUSED;
                     if (op_reg == FSCR_OP_PROGRAM) begin
                        ppause_next = 1'b1;
                     end else begin
                        epause_next = 1'b1;
                     end
                  end
               end
               FSCR_RESUME: begin
                  ok = (phase_reg == FSCR_PAUSED);
                  if (ok) begin
                     epause_next = 1'b0;
                     ppause_next = 1'b0;
                     phase_next  = FSCR_ARRAY_RUN;
                  end
               end
               FSCR_SOFT_RESET: begin
                  // a pending status write still completes
                  ok          = 1'b1;
                  latch_next  = 1'b0;
                  epause_next = 1'b0;
                  ppause_next = 1'b0;
                  if (phase_reg == FSCR_PAUSED) begin
                     phase_next = FSCR_IDLE;
                  end
               end
               default: begin
                  ok = 1'b0;
               end
            endcase
            accept_next = ok;
            reject_next = !ok;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_reg  <= FSCR_IDLE;
         prot_reg   <= PROT_RESET;
         lock_reg   <= LOCK_RESET;
         invert_reg <= INVERT_RESET;
         otp_reg    <= OTP_RESET;
         dummy_reg  <= DUMMY_RESET;
         drive_reg  <= STRENGTH_RESET;
         latch_reg  <= 1'b0;
         epause_reg <= 1'b0;
         ppause_reg <= 1'b0;
         pend_reg   <= 8'h00;
         sel_reg    <= 2'h0;
         timer_reg  <= 16'h0000;
         op_reg     <= FSCR_OP_PROGRAM;
         accept_reg <= 1'b0;
         reject_reg <= 1'b0;
         array_reg  <= '0;
      end else begin
         phase_reg  <= phase_next;
         prot_reg   <= prot_next;
         lock_reg   <= lock_next;
         invert_reg <= invert_next;
         otp_reg    <= otp_next;
         dummy_reg  <= dummy_next;
         drive_reg  <= drive_next;
         latch_reg  <= latch_next;
         epause_reg <= epause_next;
         ppause_reg <= ppause_next;
         pend_reg   <= pend_next;
         sel_reg    <= sel_next;
         timer_reg  <= timer_next;
         op_reg     <= op_next;
         accept_reg <= accept_next;
         reject_reg <= reject_next;
         array_reg  <= array_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; reserved bits read zero
   always_comb begin
      status = '0;
      status.sr1[BUSY_BIT]                = busy;
      status.sr1[LATCH_BIT]               = latch_reg;
      status.sr1[PROT_HI_BIT:PROT_LO_BIT] = prot_reg;
      status.sr1[LOCK_LO_BIT]             = lock_reg[0];
      status.sr2[LOCK_HI_BIT]             = lock_reg[1];
      status.sr2[QUAD_BIT]                = 1'b1;
      status.sr2[PPAUSE_BIT]              = ppause_reg;
      status.sr2[OTP_HI_BIT:OTP_LO_BIT]   = otp_reg;
      status.sr2[INVERT_BIT]              = invert_reg;
      status.sr2[EPAUSE_BIT]              = epause_reg;
      status.sr3[DUMMY_BIT]               = dummy_reg;
      status.sr3[STRENGTH_HI:STRENGTH_LO] = drive_reg;
   end

   assign cmd_accept = accept_reg;
   assign cmd_reject = reject_reg;
   assign array_cmd  = array_reg;
   assign array_hold = (phase_reg == FSCR_PAUSED);
   assign dummy_dual = dummy_reg ? DUMMY_DUAL_1 : DUMMY_DUAL_0;
   assign dummy_quad = dummy_reg ? DUMMY_QUAD_1 : DUMMY_QUAD_0;
   assign strength   = drive_reg;
   assign quad_on    = 1'b1;
   assign otp_locked = otp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_sr_req;
      req.valid && !power_cycle && (req.code inside {FSCR_STATUS_WRITE_1,
         FSCR_STATUS_WRITE_2, FSCR_STATUS_WRITE_3});
   endsequence

   a_latch_gates_sr: assert property (s_sr_req and !latch_reg |=> cmd_reject)
      else $error("status write taken with write latch low");
   a_lock_blocks_sr: assert property (s_sr_req and lock_reg[1] |=> cmd_reject)
      else $error("status write taken while locked");
   a_otp_sticky: assert property (!power_cycle |=> (otp_reg & $past(otp_reg)) == $past(otp_reg))
      else $error("security lock bit cleared");
   a_quad_fixed: assert property (status.sr2[QUAD_BIT] && quad_on)
      else $error("quad enable not one");
   a_lockdown_release: assert property (power_cycle && lock_reg == LOCK_DOWN
      |=> lock_reg == LOCK_OPEN)
      else $error("lock-down survived power cycle");
   // busy length follows WRITE_CYCLES, so it is checked via the timer, not a fixed repeat
   a_sr_busy_time: assert property (s_sr_req and latch_reg and !lock_reg[1]
      and phase_reg == FSCR_IDLE |=> status.sr1[BUSY_BIT] && timer_reg == 16'(WRITE_CYCLES))
      else $error("status write did not start its busy time");
   a_sr_busy_hold: assert property (phase_reg == FSCR_SR_WRITE && timer_reg != 16'h0001
      && !power_cycle |=> status.sr1[BUSY_BIT])
      else $error("busy dropped during status write");
   a_chip_guard: assert property (req.valid && !power_cycle && req.code == FSCR_CHIP_WIPE
      && !chip_ok |=> cmd_reject && !array_cmd.start)
      else $error("whole erase started outside allowed setting");
   a_prot_guard: assert property (req.valid && !power_cycle && in_prot
      && req.code inside {FSCR_PAGE_WRITE, FSCR_SECTOR_WIPE, FSCR_BLOCK_WIPE}
      |=> cmd_reject && !array_cmd.start)
      else $error("protected area program or erase started");
   a_resume_clears: assert property (req.valid && !power_cycle && req.code == FSCR_RESUME
      && phase_reg == FSCR_PAUSED |=> !epause_reg && !ppause_reg && busy)
      else $error("pause flag kept after resume");
   a_done_clears: assert property (phase_reg == FSCR_ARRAY_RUN && array_done && !power_cycle
      |=> !latch_reg && !busy)
      else $error("write latch kept after array operation");

endmodule : fscr_bank
`default_nettype wire

// ===== hw/fscr_pkg.sv
// shared constants and types of the flash status and configuration bank
package fscr_pkg;

   // bit positions inside status byte 1
   localparam int BUSY_BIT      = 0;
   localparam int LATCH_BIT     = 1;
   localparam int PROT_LO_BIT   = 2;
   localparam int PROT_HI_BIT   = 6;
   localparam int LOCK_LO_BIT   = 7;
   // bit positions inside status byte 2
   localparam int LOCK_HI_BIT   = 0;
   localparam int QUAD_BIT      = 1;
   localparam int PPAUSE_BIT    = 2;
   localparam int OTP_LO_BIT    = 3;
   localparam int OTP_HI_BIT    = 5;
   localparam int INVERT_BIT    = 6;
   localparam int EPAUSE_BIT    = 7;
   // bit positions inside status byte 3
   localparam int DUMMY_BIT     = 0;
   localparam int STRENGTH_LO   = 5;
   localparam int STRENGTH_HI   = 6;

   // reset values of the non-volatile fields, then the two lock mode codes
   localparam logic [4:0] PROT_RESET     = 5'h00;
   localparam logic [1:0] LOCK_RESET     = 2'h0;
   localparam logic       INVERT_RESET   = 1'h0;
   localparam logic [2:0] OTP_RESET      = 3'h0;
   localparam logic       DUMMY_RESET    = 1'h0;
   localparam logic [1:0] STRENGTH_RESET = 2'h1;
   localparam logic [1:0] LOCK_DOWN      = 2'h2;
   localparam logic [1:0] LOCK_OPEN      = 2'h0;

   // dummy cycles of the two fast read modes, selected by the dummy bit of status byte 3
   localparam logic [3:0] DUMMY_DUAL_0 = 4'h4;
   localparam logic [3:0] DUMMY_DUAL_1 = 4'h8;
   localparam logic [3:0] DUMMY_QUAD_0 = 4'h6;
   localparam logic [3:0] DUMMY_QUAD_1 = 4'hA;

   // internal status write time in clock cycles
   localparam int SR_WRITE_CYCLES = 16;
   localparam int ADDR_W          = 22;

   typedef enum logic [3:0] {
      FSCR_ENABLE_WRITE,
      FSCR_DISABLE_WRITE,
      FSCR_STATUS_WRITE_1,
      FSCR_STATUS_WRITE_2,
      FSCR_STATUS_WRITE_3,
      FSCR_PAGE_WRITE,
      FSCR_SECTOR_WIPE,
      FSCR_BLOCK_WIPE,
      FSCR_CHIP_WIPE,
      FSCR_SUSPEND,
      FSCR_RESUME,
      FSCR_SOFT_RESET
   } fscr_cmd_t;

   typedef enum logic [1:0] {
      FSCR_OP_PROGRAM,
      FSCR_OP_SECTOR,
      FSCR_OP_BLOCK,
      FSCR_OP_CHIP
   } fscr_op_t;

   typedef struct packed {
      logic              valid;
      fscr_cmd_t         code;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } fscr_req_t;

   typedef struct packed {
      logic              start;
      fscr_op_t          kind;
      logic [ADDR_W-1:0] addr;
   } fscr_array_t;

   typedef struct packed {
      logic [7:0] sr3;
      logic [7:0] sr2;
      logic [7:0] sr1;
   } fscr_status_t;

endpackage : fscr_pkg

// ===== hw/fscr_guard.sv
// protected-region decode from protect range and invert bits
`timescale 1ns/1ps
`default_nettype none
module fscr_guard
   import fscr_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   input  wire logic [4:0]    prot,
   input  wire logic          invert,
   input  wire logic [AW-1:0] addr,
   output logic               hit
);
   localparam logic [AW-1:0] ADDR_TOP = {AW{1'b1}};

   logic [4:0]    k;
   logic [AW-1:0] upper;
   logic [AW-1:0] limit;
   logic          base;

   generate
      if (AW < 16) begin : g_bad_width
         $error("fscr_guard: address width too small");
      end
   endgenerate

   always_comb begin
      // region of 2**k bytes at the top (range_3 = 0) or bottom of the array
      if (prot[4]) begin
         k = prot[2] ? 5'd15 : 5'(5'd11 + {3'h0, prot[1:0]});
      end else begin
         k = 5'(5'd15 + {2'h0, prot[2:0]});
      end
      upper = addr >> k;
      limit = ADDR_TOP >> k;
      if (prot[2:0] == 3'h0) begin
         base = 1'b0;
      end else if (prot[2:0] == 3'h7) begin
         base = 1'b1;
      end else if (!prot[3]) begin
         base = (upper == limit);
      end else begin
         base = (upper == '0);
      end
      hit = base ^ invert;
   end
endmodule : fscr_guard
`default_nettype wire

// ===== sim/fscr_host.sv
// host controller and array engine model driving the bank's command side
`timescale 1ns/1ps
`default_nettype none
module fscr_host
   import fscr_pkg::*;
(
   input  wire logic      clk,
   output var fscr_req_t  req,
   output var logic       array_done,
   output var logic       power_cycle
);
   initial begin
      req         = '0;
      array_done  = 1'b0;
      power_cycle = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one command per call; valid is a single-cycle pulse, so addr and data are
   // scrambled once it drops, while code is left showing the old command
   task send(input fscr_cmd_t code, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
      @(posedge clk);
      req <= '{valid: 1'b1, code: code, addr: addr,
               data: (code == FSCR_STATUS_WRITE_3) ? (data & 8'h61) : data};
      @(posedge clk);
      req <= '{valid: 1'b0, code: code, addr: ~addr, data: ~data};
      #1;
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   // array engine reports completion only when told, so a running op can be paused
   task finish;
      @(posedge clk);
      array_done <= 1'b1;
      @(posedge clk);
      array_done <= 1'b0;
      #1;
   endtask : finish
   task power;
      @(posedge clk);
      power_cycle <= 1'b1;
      @(posedge clk);
      power_cycle <= 1'b0;
      #1;
   endtask : power
endmodule : fscr_host
`default_nettype wire

// ===== sim/fscr_bank_bench.sv
// self-checking bench of the flash status and configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module fscr_bank_bench
   import fscr_pkg::*;
;
   // short status write keeps the run brief; waits are derived from it
   localparam int W = 4;
   logic         clk;
   logic         arst_n;
   fscr_req_t    req;
   logic         array_done;
   logic         power_cycle;
   fscr_status_t status;
   logic         cmd_accept;
   logic         cmd_reject;
   fscr_array_t  array_cmd;
   logic         array_hold;
   logic [3:0]   dummy_dual;
   logic [3:0]   dummy_quad;
   logic [1:0]   strength;
   logic         quad_on;
   logic [2:0]   otp_locked;
   int           bad_count = 0;
   int           n_checks = 0;

   fscr_bank #(.WRITE_CYCLES(W)) dut (.clk(clk), .arst_n(arst_n), .power_cycle(power_cycle),
      .req(req), .array_done(array_done), .status(status), .cmd_accept(cmd_accept),
      .cmd_reject(cmd_reject), .array_cmd(array_cmd), .array_hold(array_hold),
      .dummy_dual(dummy_dual), .dummy_quad(dummy_quad), .strength(strength),
      .quad_on(quad_on), .otp_locked(otp_locked));
   fscr_host host (.clk(clk), .req(req), .array_done(array_done), .power_cycle(power_cycle));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      if (bad_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   task cmd(input fscr_cmd_t code, input logic [ADDR_W-1:0] addr, input logic [7:0] data,
            input logic acc);
      host.send(code, addr, data);
      `CHK(cmd_accept, acc)
      `CHK(cmd_reject, !acc)
   endtask : cmd
   task wr_sr(input fscr_cmd_t code, input logic [7:0] data);
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(code, '0, data, 1'b1);
      `CHK(status.sr1[BUSY_BIT], 1'b1)
      repeat (W - 1) @(posedge clk);
      #1;
      `CHK(status.sr1[BUSY_BIT], 1'b1)
      @(posedge clk);
      #1;
      `CHK(status.sr1[BUSY_BIT], 1'b0)
      `CHK(status.sr1[LATCH_BIT], 1'b0)
   endtask : wr_sr
   task finish_op;
      host.finish();
      `CHK(status.sr1[BUSY_BIT], 1'b0)
      `CHK(status.sr1[LATCH_BIT], 1'b0)
   endtask : finish_op
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      `CHK(status, 24'h200200)
      `CHK(dummy_dual, 4'h4)
      `CHK(dummy_quad, 4'h6)
      `CHK(strength, 2'h1)
      `CHK(quad_on, 1'b1)
      `CHK(otp_locked, 3'h0)
   endtask : t_reset
   task t_refuse;
      cmd(FSCR_STATUS_WRITE_1, '0, 8'h1C, 1'b0);
      cmd(FSCR_PAGE_WRITE, '0, 8'h00, 1'b0);
      cmd(FSCR_SECTOR_WIPE, '0, 8'h00, 1'b0);
      cmd(FSCR_CHIP_WIPE, '0, 8'h00, 1'b0);
      cmd(FSCR_RESUME, '0, 8'h00, 1'b0);
      `CHK(status.sr1, 8'h00)
   endtask : t_refuse
   task t_protect;
      wr_sr(FSCR_STATUS_WRITE_1, 8'h07);
      `CHK(status.sr1, 8'h04)
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      `CHK(status.sr1[LATCH_BIT], 1'b1)
      cmd(FSCR_PAGE_WRITE, 22'h3F0000, 8'h00, 1'b0);
      cmd(FSCR_CHIP_WIPE, '0, 8'h00, 1'b0);
      cmd(FSCR_PAGE_WRITE, 22'h3EFFFF, 8'h00, 1'b1);
      `CHK(array_cmd, {1'b1, FSCR_OP_PROGRAM, 22'h3EFFFF})
      `CHK(status.sr1[BUSY_BIT], 1'b1)
      finish_op();
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_DISABLE_WRITE, '0, 8'h00, 1'b1);
      `CHK(status.sr1[LATCH_BIT], 1'b0)
      wr_sr(FSCR_STATUS_WRITE_2, 8'h40);
      `CHK(status.sr2, 8'h42)
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_SECTOR_WIPE, 22'h000000, 8'h00, 1'b0);
      cmd(FSCR_BLOCK_WIPE, 22'h3F0000, 8'h00, 1'b1);
      `CHK(array_cmd.kind, FSCR_OP_BLOCK)
      finish_op();
      wr_sr(FSCR_STATUS_WRITE_1, 8'h1C);
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_CHIP_WIPE, '0, 8'h00, 1'b1);
      `CHK(array_cmd.kind, FSCR_OP_CHIP)
      finish_op();
   endtask : t_protect
   task t_otp_tuning;
      wr_sr(FSCR_STATUS_WRITE_2, 8'h48);
      `CHK(status.sr2, 8'h4A)
      `CHK(otp_locked, 3'h1)
      wr_sr(FSCR_STATUS_WRITE_2, 8'h40);
      `CHK(otp_locked, 3'h1)
      wr_sr(FSCR_STATUS_WRITE_3, 8'hFF);
      `CHK(status.sr3, 8'h61)
      `CHK(dummy_dual, 4'h8)
      `CHK(dummy_quad, 4'hA)
      `CHK(strength, 2'h3)
   endtask : t_otp_tuning
   task t_pause;
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_PAGE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_SUSPEND, '0, 8'h00, 1'b1);
      `CHK({status.sr2[PPAUSE_BIT], status.sr1[BUSY_BIT], array_hold}, 3'b101)
      cmd(FSCR_RESUME, '0, 8'h00, 1'b1);
      `CHK({status.sr2[PPAUSE_BIT], status.sr1[BUSY_BIT]}, 2'b01)
      finish_op();
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_SECTOR_WIPE, '0, 8'h00, 1'b1);
      cmd(FSCR_SUSPEND, '0, 8'h00, 1'b1);
      `CHK(status.sr2[EPAUSE_BIT], 1'b1)
      cmd(FSCR_SOFT_RESET, '0, 8'h00, 1'b1);
      `CHK({status.sr2[EPAUSE_BIT], status.sr1[LATCH_BIT], array_hold}, 3'b000)
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_BLOCK_WIPE, '0, 8'h00, 1'b1);
      cmd(FSCR_SUSPEND, '0, 8'h00, 1'b1);
      host.power();
      `CHK({status.sr2[EPAUSE_BIT], status.sr1[LATCH_BIT]}, 2'b00)
      `CHK(status.sr1, 8'h1C)
   endtask : t_pause
   task t_lock;
      wr_sr(FSCR_STATUS_WRITE_2, 8'h41);
      `CHK(status.sr2, 8'h4B)
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_STATUS_WRITE_1, '0, 8'h00, 1'b0);
      host.power();
      `CHK(status.sr2, 8'h4A)
      wr_sr(FSCR_STATUS_WRITE_1, 8'h9C);
      `CHK(status.sr1, 8'h9C)
      wr_sr(FSCR_STATUS_WRITE_2, 8'h41);
      host.power();
      `CHK(status.sr2, 8'h4B)
      cmd(FSCR_ENABLE_WRITE, '0, 8'h00, 1'b1);
      cmd(FSCR_STATUS_WRITE_1, '0, 8'h00, 1'b0);
   endtask : t_lock
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      t_reset();
      t_refuse();
      t_protect();
      t_otp_tuning();
      t_pause();
      t_lock();
      report_and_stop();
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      #(40 * 5000);
      bad_count++;
      report_and_stop();
   end
endmodule : fscr_bank_bench
`default_nettype wire
